//--- src/flash_host_params.svh
// Timing constants of the flash host controller, in printed units and in cycles.
// Assumes a single system clock whose period is FH_CLK_NS.
`ifndef FLASH_HOST_PARAMS_SVH
`define FLASH_HOST_PARAMS_SVH

`define FH_CLK_NS          20
`define FH_CEIL(t)         (((t) + `FH_CLK_NS - 1) / `FH_CLK_NS)
`define FH_FLOOR(t)        ((t) / `FH_CLK_NS)

`define FH_SYNC_STAGES     2
`define FH_T_RC_NS         85
`define FH_T_WC_NS         85
`define FH_T_WP_NS         35
`define FH_T_RH_NS         50
`define FH_T_RP_NS         500
`define FH_T_READY_IDLE_NS 500
`define FH_T_READY_EMB_US  20
`define FH_T_RPD_US        20
`define FH_T_OEPH_NS       20
`define FH_T_FLQZ_NS       30
`define FH_T_FHQV_NS       85
`define FH_T_BUSY_NS       90
`define FH_T_ERASE_MS      700

`define FH_RC_CYC          `FH_CEIL(`FH_T_RC_NS)
`define FH_WC_CYC          `FH_CEIL(`FH_T_WC_NS)
`define FH_WP_CYC          `FH_CEIL(`FH_T_WP_NS)
`define FH_RH_CYC          `FH_CEIL(`FH_T_RH_NS)
`define FH_RP_CYC          `FH_CEIL(`FH_T_RP_NS)
`define FH_READY_IDLE_CYC  `FH_FLOOR(`FH_T_READY_IDLE_NS)
`define FH_READY_EMB_CYC   `FH_FLOOR(`FH_T_READY_EMB_US * 1000)
`define FH_RPD_CYC         `FH_CEIL(`FH_T_RPD_US * 1000)
`define FH_OEPH_CYC        `FH_CEIL(`FH_T_OEPH_NS)
`define FH_FLQZ_CYC        `FH_CEIL(`FH_T_FLQZ_NS)
`define FH_FHQV_CYC        `FH_CEIL(`FH_T_FHQV_NS)
`define FH_BUSY_CYC        `FH_CEIL(`FH_T_BUSY_NS)
`define FH_ERASE_CYC       (`FH_T_ERASE_MS * 1000000 / `FH_CLK_NS)

`endif

//--- src/flash_host_pkg.sv
// Types shared by the flash host controller and its bench.
// Assumes a 16-bit data bus and 21 address lines on the flash side.
package flash_host_pkg;

  localparam int ADDR_W = 21;
  localparam int DATA_W = 16;

  typedef enum logic [2:0] {
    CMD_READ       = 3'h0,
    CMD_WRITE      = 3'h1,
    CMD_WRITE_LAST = 3'h2,
    CMD_RESET      = 3'h3,
    CMD_STANDBY    = 3'h4,
    CMD_WIDTH      = 3'h5
  } cmd_e;

  typedef struct packed {
    cmd_e              cmd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } req_s;

  typedef struct packed {
    logic              done;
    logic              timeout;
    logic [DATA_W-1:0] rdata;
  } resp_s;

endpackage

//--- src/flash_cycle_timer.sv
// Loadable down counter that paces every phase of the flash host.
// Assumes the load value is the phase length minus one.
`timescale 1ns/1ps
module flash_cycle_timer #(
  parameter int TW = 26
) (
  input  wire logic          sys_clk_in,
  input  wire logic          rst_in,
  input  wire logic          load_in,
  input  wire logic [TW-1:0] value_in,
  output logic      [TW-1:0] count_out,
  output logic               zero_out
);

  logic [TW-1:0] count_q;

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      count_q <= '0;
    end else if (load_in) begin
      count_q <= value_in;
    end else if (count_q != '0) begin
      count_q <= count_q - TW'(1);
    end
  end

  assign count_out = count_q;
  assign zero_out  = (count_q == '0);

endmodule

//--- src/flash_host_ctrl.sv
// Host-side controller that runs read, write, reset and width cycles on a parallel flash.
// Assumes the user port is on sys_clk_in; flash pins are asynchronous to it.
// Function
// R01: A reset during an embedded algorithm is held until the part is back in read mode, 20 us.
// R02: A reset with no algorithm running is held until read mode is reached, 500 ns.
// R03: After reset is released no read starts for at least 50 ns.
// R04: Standby is reached only by holding reset low for at least 20 us.
// R05: A new write may start as soon as the ready/busy line is high again.
// R06: A normal program takes about 5 us per byte and 7 us per word.
// R07: An accelerated program takes about 4 us.
// R08: A sector erase takes about 0.7 s, which bounds the wait for ready.
// R09: The part drops ready/busy within 90 ns of the last command write.
// R10: Output enable stays high at least 20 ns between status reads.
// R11: Write cycles are spaced at least 85 ns apart.
// R12: Read cycles are spaced at least 85 ns apart.
// R13: Width low floats the upper byte in 30 ns; width high needs 85 ns before word data.
// R14: The part sleeps by itself when addresses stay still; the host need do nothing.
// R15: The part holds ready/busy low for the whole algorithm and releases it at the end.
`timescale 1ns/1ps
`include "flash_host_params.svh"
module flash_host_ctrl
  import flash_host_pkg::*;
#(
  parameter int TW          = 26,
  parameter int TIMEOUT_CYC = `FH_ERASE_CYC
) (
  input  wire logic              sys_clk_in,
  input  wire logic              rst_in,
  input  wire logic              req_valid_in,
  input  wire req_s              req_in,
  output logic                   req_ready_out,
  output resp_s                  resp_out,
  input  wire logic              accel_in,
  output logic                   flash_ce_n_out,
  output logic                   flash_oe_n_out,
  output logic                   flash_we_n_out,
  output logic                   flash_reset_n_out,
  output logic [ADDR_W-1:0]      flash_addr_out,
  output logic [DATA_W-1:0]      flash_dq_out,
  output logic [DATA_W-1:0]      flash_dq_oe_out,
  input  wire logic [DATA_W-1:0] flash_dq_in,
  output logic                   flash_width_select_out,
  output logic                   program_accelerate_out,
  input  wire logic              ready_busy_n_in
);

  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_RD   = 4'h1,
    S_WR   = 4'h3,
    S_GAP  = 4'h2,
    S_BDLY = 4'h6,
    S_BSY  = 4'h7,
    S_RSTL = 4'h5,
    S_RSTR = 4'h4,
    S_WID  = 4'hC
  } state_e;

  function automatic logic [TW-1:0] ld(input int n);
    ld = TW'(n - 1);
  endfunction

  function automatic int cmax(input int a, input int b);
    cmax = (a > b) ? a : b;
  endfunction

  localparam int HOLD_IDLE = cmax(`FH_RP_CYC, `FH_READY_IDLE_CYC);
  localparam int HOLD_EMB  = cmax(`FH_RP_CYC, `FH_READY_EMB_CYC);
  localparam logic [TW-1:0] WE_LOW_ABOVE = TW'(`FH_WC_CYC - `FH_WP_CYC - 1);
  localparam logic [DATA_W-1:0] LOW_BYTE = DATA_W'(16'h00FF);

  state_e            state_q, state_d;
  logic              tmr_load;
  logic [TW-1:0]     tmr_val, tmr_cnt;
  logic              tmr_zero;
  logic              last_q, last_d;
  logic              width_q, width_d;
  logic              accel_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] wdata_q, rdata_q;
  logic              done_q, timeout_q;
  logic [DATA_W-1:0] dq_m, dq_s;
  logic              rb_m, rb_s;

  flash_cycle_timer #(.TW(TW)) u_timer (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .load_in    (tmr_load),
    .value_in   (tmr_val),
    .count_out  (tmr_cnt),
    .zero_out   (tmr_zero)
  );

  // Pins are asynchronous: two stages before anything looks at them
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      dq_m <= '0;
      dq_s <= '0;
      rb_m <= 1'b1;
      rb_s <= 1'b1;
    end else begin
      dq_m <= flash_dq_in;
      dq_s <= dq_m;
      rb_m <= ready_busy_n_in;
      rb_s <= rb_m;
    end
  end

  wire accept     = req_valid_in && (state_q == S_IDLE);
  wire busy_gone  = (state_q == S_BSY) && rb_s;
  wire busy_stuck = (state_q == S_BSY) && !rb_s && tmr_zero;

  always_comb begin
    state_d  = state_q;
    tmr_load = 1'b0;
    tmr_val  = '0;
    last_d   = last_q;
    width_d  = width_q;
    case (state_q)
      S_IDLE: begin
        if (req_valid_in) begin
          tmr_load = 1'b1;
          case (req_in.cmd)
            CMD_READ: begin
              state_d = S_RD;
              tmr_val = ld(`FH_RC_CYC + `FH_SYNC_STAGES); // see R12
            end
            CMD_WRITE, CMD_WRITE_LAST: begin
              state_d = S_WR;
              tmr_val = ld(`FH_WC_CYC); // see R11
              last_d  = (req_in.cmd == CMD_WRITE_LAST);
            end
            CMD_RESET: begin
              state_d = S_RSTL;
              tmr_val = rb_s ? ld(HOLD_IDLE) : ld(HOLD_EMB); // see R01, R02
            end
            CMD_STANDBY: begin
              state_d = S_RSTL;
              tmr_val = ld(`FH_RPD_CYC); // see R04
            end
            CMD_WIDTH: begin
              state_d = S_WID;
              width_d = req_in.data[0];
              tmr_val = req_in.data[0] ? ld(`FH_FHQV_CYC) : ld(`FH_FLQZ_CYC); // see R13
            end
            default: begin
              tmr_load = 1'b0;
            end
          endcase
        end
      end
      S_RD: begin
        if (tmr_zero) begin
          state_d  = S_GAP;
          tmr_load = 1'b1;
          tmr_val  = ld(`FH_OEPH_CYC); // see R10
        end
      end
      S_WR: begin
        if (tmr_zero) begin
          tmr_load = 1'b1;
          if (last_q) begin
            // Busy may take its full delay to fall, plus the synchroniser
            state_d = S_BDLY;
            tmr_val = ld(`FH_BUSY_CYC + `FH_SYNC_STAGES); // see R09
          end else begin
            state_d = S_GAP;
            tmr_val = ld(1);
          end
        end
      end
      S_GAP: begin
        if (tmr_zero) begin
          state_d = S_IDLE;
        end
      end
      S_BDLY: begin
        if (tmr_zero) begin
          state_d  = S_BSY;
          tmr_load = 1'b1;
          tmr_val  = TW'(TIMEOUT_CYC); // see R08
        end
      end
      S_BSY: begin
        if (busy_gone || busy_stuck) begin
          state_d = S_IDLE; // see R05, R15
        end
      end
      S_RSTL: begin
        if (tmr_zero) begin
          state_d  = S_RSTR;
          tmr_load = 1'b1;
          tmr_val  = ld(`FH_RH_CYC); // see R03
        end
      end
      S_RSTR, S_WID: begin
        if (tmr_zero) begin
          state_d = S_IDLE;
        end
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= S_IDLE;
      last_q  <= 1'b0;
      width_q <= 1'b1;
      accel_q <= 1'b0;
    end else begin
      state_q <= state_d;
      last_q  <= last_d;
      width_q <= width_d;
      accel_q <= accel_in; // see R07
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      addr_q  <= '0;
      wdata_q <= '0;
    end else if (accept) begin
      addr_q  <= req_in.addr;
      wdata_q <= req_in.data;
    end
  end

  // Data is sampled only after the access time has passed the synchroniser
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_q   <= '0;
      done_q    <= 1'b0;
      timeout_q <= 1'b0;
    end else begin
      if ((state_q == S_RD) && tmr_zero) begin
        rdata_q <= width_q ? dq_s : (dq_s & LOW_BYTE);
      end
      done_q <= (state_q != S_IDLE) && (state_d == S_IDLE);
      if (accept) begin
        timeout_q <= 1'b0;
      end else if (busy_stuck) begin
        timeout_q <= 1'b1;
      end
    end
  end

  assign req_ready_out          = (state_q == S_IDLE);
  assign resp_out               = '{done: done_q, timeout: timeout_q, rdata: rdata_q};
  assign flash_ce_n_out         = !((state_q == S_RD) || (state_q == S_WR));
  assign flash_oe_n_out         = (state_q != S_RD);
  assign flash_we_n_out         = !((state_q == S_WR) && (tmr_cnt > WE_LOW_ABOVE)); // see R11
  assign flash_reset_n_out      = (state_q != S_RSTL);
  assign flash_addr_out         = addr_q;
  assign flash_dq_out           = wdata_q;
  // Byte mode never drives the upper lanes; the part floats them
  assign flash_dq_oe_out        = (state_q != S_WR) ? '0 : (width_q ? '1 : LOW_BYTE); // see R13
  assign flash_width_select_out = width_q;
  assign program_accelerate_out = accel_q;

  // Checking helpers: reset-low length and what kind of reset it was
  logic [11:0] low_cnt_q;
  logic        stby_q, emb_q;
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      low_cnt_q <= '0;
      stby_q    <= 1'b0;
      emb_q     <= 1'b0;
    end else begin
      if (flash_reset_n_out) begin
        low_cnt_q <= '0;
      end else if (low_cnt_q != 12'hFFF) begin
        low_cnt_q <= low_cnt_q + 12'h001;
      end
      if (accept) begin
        stby_q <= (req_in.cmd == CMD_STANDBY);
        emb_q  <= !rb_s;
      end
    end
  end

  localparam int RPD_MIN   = `FH_RPD_CYC;
  localparam int EMB_MIN   = `FH_READY_EMB_CYC;
  localparam int IDLE_MIN  = `FH_READY_IDLE_CYC;

  sequence read_strobe;
    !flash_oe_n_out [*7];
  endsequence
  sequence write_strobe;
    !flash_we_n_out [*2] ##1 (flash_we_n_out && !flash_ce_n_out) [*3];
  endsequence

  a_read_spacing: assert property (@(posedge sys_clk_in) disable iff (rst_in) // see R12
    $fell(flash_oe_n_out) |-> read_strobe)
    else $error("read strobe shorter than access plus sync");
  a_write_pulse: assert property (@(posedge sys_clk_in) disable iff (rst_in) // see R11
    $fell(flash_we_n_out) |-> write_strobe ##1 flash_ce_n_out)
    else $error("write cycle shape wrong");
  a_oe_gap: assert property (@(posedge sys_clk_in) disable iff (rst_in) // see R10
    $rose(flash_oe_n_out) |-> (state_q == S_GAP) ##1 flash_oe_n_out)
    else $error("output enable high gap missing");
  a_reset_recovery: assert property (@(posedge sys_clk_in) disable iff (rst_in) // see R03
    $rose(flash_reset_n_out) |-> flash_oe_n_out [*3])
    else $error("read too soon after reset release");
  a_standby_hold: assert property (@(posedge sys_clk_in) disable iff (rst_in) // see R04
    ($rose(flash_reset_n_out) && stby_q) |-> (low_cnt_q >= 12'(RPD_MIN)))
    else $error("standby reset too short");
  a_ready_emb: assert property (@(posedge sys_clk_in) disable iff (rst_in) // see R01
    ($rose(flash_reset_n_out) && emb_q) |-> (low_cnt_q >= 12'(EMB_MIN)))
    else $error("reset during algorithm too short");
  a_ready_idle: assert property (@(posedge sys_clk_in) disable iff (rst_in) // see R02
    ($rose(flash_reset_n_out) && !stby_q && !emb_q) |-> (low_cnt_q >= 12'(IDLE_MIN)))
    else $error("idle reset too short");
  a_busy_release: assert property (@(posedge sys_clk_in) disable iff (rst_in) // see R05
    ((state_q == S_BSY) && rb_s) |=> (state_q == S_IDLE) && resp_out.done)
    else $error("busy release not followed");
  a_busy_delay: assert property (@(posedge sys_clk_in) disable iff (rst_in) // see R09
    ((state_q == S_WR) && last_q && tmr_zero) |=> (state_q == S_BDLY) [*7] ##1 (state_q == S_BSY))
    else $error("busy sample delay wrong");
  a_width_settle: assert property (@(posedge sys_clk_in) disable iff (rst_in) // see R13
    $rose(flash_width_select_out) |-> (state_q == S_WID) [*5] ##1 (state_q == S_IDLE))
    else $error("word width settle wrong");

endmodule

//--- tb/flash_dev_model.sv
// Behavioural flash part that answers the host controller pins.
// Assumes the host drives all control pins; times are in ns, 256 words kept.
`timescale 1ns/1ps
module flash_dev_model
  import flash_host_pkg::*;
#(
  parameter int ERASE_NS = 40000
) (
  input  wire logic              ce_n_in,
  input  wire logic              oe_n_in,
  input  wire logic              we_n_in,
  input  wire logic              reset_n_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [DATA_W-1:0] dq_in,
  input  wire logic [DATA_W-1:0] dq_oe_in,
  input  wire logic              width_in,
  input  wire logic              accel_in,
  output logic      [DATA_W-1:0] dq_out,
  output logic                   ready_busy_n_out,
  output int                     standby_cnt_out
);
  logic [DATA_W-1:0] mem [0:255];
  logic [DATA_W-1:0] last_q;
  int                op_id;
  int                rst_id;
  wire               drive = !ce_n_in && !oe_n_in && reset_n_in;

  initial begin
    ready_busy_n_out = 1'b1;
    standby_cnt_out = 0;
    last_q = 16'h0000;
    op_id = 0;
    rst_id = 0;
    for (int i = 0; i < 256; i++) mem[i] = 16'hFFFF;
  end

  // Released lines show the inverse of the last read, never a stale copy
  // Data stays valid while the part sleeps on a still address
  always_comb begin
    for (int i = 0; i < DATA_W; i++) begin
      dq_out[i] = dq_oe_in[i] ? dq_in[i] : ~last_q[i];
      if (drive && (width_in || i < 8)) dq_out[i] = mem[addr_in[7:0]][i];
    end
  end

  always @(posedge oe_n_in) last_q = mem[addr_in[7:0]];

  function automatic int op_ns(logic [DATA_W-1:0] d);
    if (d == 16'h0030) return ERASE_NS;
    if (accel_in) return 4000;
    return width_in ? 7000 : 5000;
  endfunction

  task automatic run_op(int id, int ns);
    #60 if (id == op_id) ready_busy_n_out = 1'b0;
    #(ns) if (id == op_id) ready_busy_n_out = 1'b1;
  endtask

  // Busy part needs time to abort; one ns short of the hold avoids an edge race
  task automatic abort(int id, logic busy);
    #(busy ? 10000 : 0) if (id == rst_id) ready_busy_n_out = 1'b1;
    #(busy ? 9999 : 19999) if (id == rst_id && !reset_n_in) standby_cnt_out++;
  endtask

  always @(posedge we_n_in) begin
    if (!ce_n_in && reset_n_in) begin
      mem[addr_in[7:0]] = dq_in & dq_oe_in;
      op_id++;
      fork
        run_op(op_id, op_ns(dq_in));
      join_none
    end
  end

  always @(negedge reset_n_in) begin
    rst_id++;
    op_id++;
    fork
      abort(rst_id, !ready_busy_n_out);
    join_none
  end
endmodule

//--- tb/flash_host_ctrl_tb.sv
// Self-checking bench of the flash host controller with a behavioural part.
// Assumes flash_dev_model on the far side; one 50 MHz clock.
`timescale 1ns/1ps
module flash_host_ctrl_tb;
  import flash_host_pkg::*;
  localparam int TMO = 600;
  logic              sys_clk_in, rst_in, req_valid_in, accel_in, req_ready_out;
  req_s              req_in;
  resp_s             resp_out;
  logic              ce_n, oe_n, we_n, rst_n, wsel, acc, rb_n;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] dq_o, dq_oe, dq_i;
  logic [15:0]       shadow [0:255];
  logic [31:0]       seed = 32'h9;
  int                fails = 0, n_compared = 0, cycles = 0, stby, standby_cnt;
  realtime           t_oe_fall = -1000, t_oe_rise = -1000, t_we_fall = -1000;
  realtime           t_rst_rise = -1000, t_rst_fall = 0, rst_low = 0;

  flash_host_ctrl #(.TIMEOUT_CYC(TMO)) uut (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .req_valid_in(req_valid_in),
    .req_in(req_in), .req_ready_out(req_ready_out), .resp_out(resp_out),
    .accel_in(accel_in), .flash_ce_n_out(ce_n), .flash_oe_n_out(oe_n),
    .flash_we_n_out(we_n), .flash_reset_n_out(rst_n), .flash_addr_out(addr),
    .flash_dq_out(dq_o), .flash_dq_oe_out(dq_oe), .flash_dq_in(dq_i),
    .flash_width_select_out(wsel), .program_accelerate_out(acc),
    .ready_busy_n_in(rb_n));

  flash_dev_model part (
    .ce_n_in(ce_n), .oe_n_in(oe_n), .we_n_in(we_n), .reset_n_in(rst_n),
    .addr_in(addr), .dq_in(dq_o), .dq_oe_in(dq_oe), .width_in(wsel),
    .accel_in(acc), .dq_out(dq_i), .ready_busy_n_out(rb_n),
    .standby_cnt_out(standby_cnt));

  initial begin
    sys_clk_in = 1'b0;
    forever #10 sys_clk_in = ~sys_clk_in;
  end

  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [15:0] exp_rd(logic [15:0] d, logic word);
    return word ? d : {8'h00, d[7:0]};
  endfunction

  function automatic int prog_ns(logic fast, logic word);
    return fast ? 4000 : (word ? 7000 : 5000);
  endfunction

  // Ready is high again in the cycle done shows, so no wait before driving
  task automatic op(cmd_e c, logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d, output int n);
    req_in = '{c, a, d};
    req_valid_in = 1'b1;
    @(posedge sys_clk_in) #1;
    req_valid_in = 1'b0;
    n = 0;
    while (resp_out.done !== 1'b1 && n < 3000) begin
      @(posedge sys_clk_in) #1;
      n++;
    end
  endtask

  always @(negedge oe_n) begin
    check("oe high gap", 1, $realtime - t_oe_rise >= 20);
    check("read spacing", 1, $realtime - t_oe_fall >= 85);
    check("reset to read", 1, $realtime - t_rst_rise >= 50);
    t_oe_fall = $realtime;
  end
  always @(posedge oe_n) t_oe_rise = $realtime;
  always @(negedge we_n) begin
    check("write spacing", 1, $realtime - t_we_fall >= 85);
    t_we_fall = $realtime;
  end
  always @(negedge rst_n) t_rst_fall = $realtime;
  always @(posedge rst_n) begin
    t_rst_rise = $realtime;
    rst_low = t_rst_rise - t_rst_fall;
  end

  // Ceiling well above the roughly 3700 cycles the sequence needs
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      results();
    end
  end

  initial begin
    int n;
    logic [31:0] r;
    rst_in = 1'b1;
    req_valid_in = 1'b0;
    req_in = '0;
    accel_in = 1'b0;
    for (int i = 0; i < 256; i++) shadow[i] = 16'hFFFF;
    repeat (8) @(posedge sys_clk_in);
    #1 rst_in = 1'b0;
    // Bit 24 set keeps random data off the erase confirm code
    for (int i = 0; i < 12; i++) begin
      r = (i == 0) ? 32'h0 : (i == 1) ? 32'hFFFF_00FF : rnd() | 32'h0100_0000;
      op(CMD_WRITE, ADDR_W'(r[7:0]), r[31:16], n);
      check("write done", 6, n);
      shadow[r[7:0]] = r[31:16];
      op(CMD_READ, ADDR_W'(r[7:0]), 16'h0000, n);
      check("read done", 8, n);
      check("read data", shadow[r[7:0]], resp_out.rdata);
    end
    for (int m = 0; m < 3; m++) begin
      accel_in = (m == 1);
      if (m == 2) begin
        op(CMD_WIDTH, '0, 16'h0000, n);
        check("byte mode", 0, wsel);
      end
      r = rnd() | 32'h0100_0000;
      op(CMD_WRITE_LAST, ADDR_W'(r[7:0]), r[31:16], n);
      shadow[r[7:0]] = exp_rd(r[31:16], m != 2);
      check("accel pin", m == 1, acc);
      check("program min", 1, n * 20 >= prog_ns(m == 1, m != 2));
      check("program end", 1, n * 20 < prog_ns(m == 1, m != 2) + 1000);
      check("ready after", 1, rb_n);
      check("no timeout", 0, resp_out.timeout);
      op(CMD_READ, ADDR_W'(r[7:0]), 16'h0000, n);
      check("read back", shadow[r[7:0]], resp_out.rdata);
    end
    accel_in = 1'b0;
    op(CMD_WIDTH, '0, 16'h0001, n);
    check("word gap", 1, n * 20 >= 85);
    check("word mode", 1, wsel);
    op(CMD_RESET, '0, 16'h0000, n);
    check("short reset", 1, rst_low >= 500 && rst_low < 20000);
    op(CMD_READ, ADDR_W'(8'hFF), 16'h0000, n);
    check("read after reset", shadow[8'hFF], resp_out.rdata);
    op(CMD_WRITE_LAST, '0, 16'h0030, n);
    check("erase bounded", 1, resp_out.timeout);
    check("still busy", 0, rb_n);
    stby = standby_cnt;
    op(CMD_RESET, '0, 16'h0000, n);
    check("long reset", 1, rst_low >= 20000);
    check("abort ready", 1, rb_n);
    check("timeout clear", 0, resp_out.timeout);
    op(CMD_STANDBY, '0, 16'h0000, n);
    check("standby hold", 1, rst_low >= 20000);
    check("standby count", stby + 2, standby_cnt);
    op(CMD_READ, ADDR_W'(8'hFF), 16'h0000, n);
    check("read after standby", shadow[8'hFF], resp_out.rdata);
    results();
  end
endmodule
